// >>> led_port_pkg.sv
/*
 * Constants and types shared by the LED driver serial register port.
 * Assumes a 100 MHz system clock and a serial bus master on the pins.
 */
package led_port_pkg;

    // =========================================================
    // Register map
    // =========================================================
    localparam logic [3:0] reg_count = 4'ha;
    localparam logic [3:0] pin_input_low_addr = 4'h0;
    localparam logic [3:0] pin_input_high_addr = 4'h1;
    localparam logic [3:0] rate0_prescale_addr = 4'h2;
    localparam logic [3:0] rate0_duty_addr = 4'h3;
    localparam logic [3:0] rate1_prescale_addr = 4'h4;
    localparam logic [3:0] rate1_duty_addr = 4'h5;
    localparam logic [3:0] out_select_0_3_addr = 4'h6;
    localparam logic [3:0] last_reg_addr = 4'h9;
    localparam logic [3:0] write_wrap_addr = 4'h2;
    localparam logic [3:0] read_wrap_addr = 4'h0;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [7:0] prescale_reset = 8'h00;
    localparam logic [7:0] duty_reset = 8'h80;
    localparam logic [7:0] select_reset = 8'h00;

    // =========================================================
    // Byte fields
    // =========================================================
    localparam int auto_advance_bit = 4;
    localparam logic [3:0] fixed_addr_high = 4'h6;
    localparam logic [2:0] bit_count_last = 3'h7;

    // =========================================================
    // Selector codes and timing
    // =========================================================
    localparam logic [1:0] sel_hiz = 2'h0;
    localparam logic [1:0] sel_low = 2'h1;
    localparam logic [1:0] sel_rate0 = 2'h2;
    localparam logic [1:0] sel_rate1 = 2'h3;
    localparam int clk_hz = 100_000_000;
    localparam int tick_hz = 160 * 256;
    localparam int tick_cycles = clk_hz / tick_hz;

    typedef struct packed {
        logic [7:0] prescale;
        logic [7:0] duty;
    } rate_cfg_t;

    typedef enum logic [5:0] {
        st_idle = 6'h01,
        st_addr = 6'h02,
        st_ack = 6'h04,
        st_rx = 6'h08,
        st_tx = 6'h10,
        st_tx_ack = 6'h20
    } port_state_t;

endpackage

// >>> led_port.sv
/*
 * Serial slave register port and output stage of a 16-output LED driver.
 * The serial logic runs on the bus clock itself (scl_in rising and falling
 * edges); registers live in the clk_in domain. Bytes cross by toggles.
 * Start and stop are seen through sda_in edges while scl_in is high.
 */
`timescale 1ns/100ps

// Functional notes
// - Power-on reset loads all register defaults.
// - Low reset pin restores defaults; program after.
// - Data changes only while serial clock low.
// - Detect start and stop conditions.
// - Bus busy from start until stop.
// - Repeated start restarts address reception.
// - Bytes are eight bits, MSB first.
// - Unlimited bytes per transfer.
// - Acknowledge by pulling data low, 9th clock.
// - Seven-bit address plus direction bit.
// - Upper address bits fixed, three from pins.
// - Write: address, register address, data bytes.
// - Register-address bit 4 enables auto advance.
// - Read advance wraps from 09H to 00H.
// - Write advance wraps from 09H to 02H.
// - Writes to input registers acked, discarded.
// - No advance: writes repeat same register.
// - Registers 0x00, 0x01 read output pin levels.
// - Two prescale and duty pairs set rates.
// - Four selectors, two bits per output.
// - Codes: hi-z, low, rate 0, rate 1.
// - Period (prescale+1)/160 s, duty value/256.
// - Input bit n reflects output pin n.
module led_port
    import led_port_pkg::*;
#(
    parameter int outputs = 16
) (
    // System clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic rst_n_in,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [2:0] addr_sel_in,
    // LED output pins
    input wire logic [outputs-1:0] drive_in,
    output logic [outputs-1:0] drive_out,
    output logic [outputs-1:0] drive_oe_out,
    output logic bus_busy_out
);

    // =========================================================
    // Reset and pin synchronisers in the system domain
    // =========================================================
    logic rst_meta_reg, rst_sync_reg, sys_rst;
    logic [outputs-1:0] pin_meta_reg, pin_sync_reg;
    logic [2:0] asel_meta_reg, asel_sync_reg;

    always_ff @(posedge clk_in) begin
        rst_meta_reg <= rst_n_in;
        rst_sync_reg <= rst_meta_reg;
    end
    assign sys_rst = reset_in | ~rst_sync_reg;

    always_ff @(posedge clk_in) begin
        pin_meta_reg <= drive_in;
        pin_sync_reg <= pin_meta_reg;
        asel_meta_reg <= addr_sel_in;
        asel_sync_reg <= asel_meta_reg;
    end

    // =========================================================
    // Start and stop detection on the data line
    // =========================================================
    // A start is an sda fall while scl is high; the serial engine resets
    // its bit state from it. The start flag clears on the next scl rise.
    logic start_tgl_reg, start_seen_reg, stop_tgl_reg;
    logic start_ack_reg;

    always_ff @(negedge sda_in or posedge reset_in) begin
        if (reset_in) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    always_ff @(posedge sda_in or posedge reset_in) begin
        if (reset_in) begin
            stop_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            stop_tgl_reg <= ~stop_tgl_reg;
        end
    end

    // =========================================================
    // Serial engine on scl
    // =========================================================
    port_state_t state_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic reading_reg, matched_reg;
    logic byte_tgl_reg, ptr_tgl_reg;
    logic [7:0] byte_hold_reg;
    logic [7:0] tx_byte_reg;
    logic [7:0] rd_data_meta_reg, rd_data_sync_reg;
    logic busy_reg;
    logic [7:0] rx_byte;

    assign rx_byte = {shift_reg[6:0], sda_in};
    always_ff @(posedge scl_in or posedge reset_in) begin
        if (reset_in) begin
            start_ack_reg <= 1'b0;
        end else begin
            start_ack_reg <= start_tgl_reg;
        end
    end
    assign start_seen_reg = start_ack_reg ^ start_tgl_reg;

    // Read data crosses into the scl domain; stable long before use.
    always_ff @(posedge scl_in) begin
        rd_data_meta_reg <= tx_byte_reg;
        rd_data_sync_reg <= rd_data_meta_reg;
    end

    always_ff @(posedge scl_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= st_idle;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            reading_reg <= 1'b0;
            matched_reg <= 1'b0;
            byte_tgl_reg <= 1'b0;
            ptr_tgl_reg <= 1'b0;
            byte_hold_reg <= 8'h00;
        end else if (start_seen_reg) begin
            state_reg <= st_addr;
            bit_reg <= 3'h1;
            shift_reg <= {7'h00, sda_in};
            matched_reg <= 1'b0;
        end else begin
            case (state_reg)
                st_addr, st_rx: begin
                    shift_reg <= rx_byte;
                    bit_reg <= bit_reg + 3'h1;
                    if (bit_reg == bit_count_last) begin
                        if (state_reg == st_addr) begin
                            matched_reg <= rx_byte[7:1] ==
                                {fixed_addr_high, asel_sync_reg};
                            reading_reg <= rx_byte[0];
                            state_reg <= st_ack;
                        end else begin
                            byte_hold_reg <= rx_byte;
                            byte_tgl_reg <= ~byte_tgl_reg;
                            state_reg <= st_ack;
                        end
                    end
                end
                st_ack: begin
                    bit_reg <= 3'h0;
                    if (!matched_reg) begin
                        state_reg <= st_idle;
                    end else if (reading_reg) begin
                        shift_reg <= rd_data_sync_reg;
                        ptr_tgl_reg <= ~ptr_tgl_reg;
                        state_reg <= st_tx;
                    end else begin
                        state_reg <= st_rx;
                    end
                end
                st_tx: begin
                    bit_reg <= bit_reg + 3'h1;
                    if (bit_reg == bit_count_last) begin
                        state_reg <= st_tx_ack;
                    end
                end
                st_tx_ack: begin
                    bit_reg <= 3'h0;
                    if (sda_in) begin
                        state_reg <= st_idle;
                    end else begin
                        ptr_tgl_reg <= ~ptr_tgl_reg;
                        shift_reg <= rd_data_sync_reg;
                        state_reg <= st_tx;
                    end
                end
                default: state_reg <= st_idle;
            endcase
        end
    end

    // Data line driven on scl falling edges only.
    always_ff @(negedge scl_in or posedge reset_in) begin
        if (reset_in) begin
            sda_oe_out <= 1'b0;
        end else if (state_reg == st_ack && matched_reg) begin
            sda_oe_out <= 1'b1;
        end else if (state_reg == st_tx) begin
            sda_oe_out <= ~shift_reg[bit_count_last - bit_reg];
        end else begin
            sda_oe_out <= 1'b0;
        end
    end
    assign sda_out = 1'b0;

    // =========================================================
    // Byte and pointer events into the system domain
    // =========================================================
    logic [2:0] byte_sync_reg, ptr_sync_reg, start_sync_reg, stop_sync_reg;
    logic byte_evt, ptr_evt, start_evt, stop_evt;

    always_ff @(posedge clk_in) begin
        byte_sync_reg <= {byte_sync_reg[1:0], byte_tgl_reg};
        ptr_sync_reg <= {ptr_sync_reg[1:0], ptr_tgl_reg};
        start_sync_reg <= {start_sync_reg[1:0], start_tgl_reg};
        stop_sync_reg <= {stop_sync_reg[1:0], stop_tgl_reg};
    end
    assign byte_evt = byte_sync_reg[2] ^ byte_sync_reg[1];
    assign ptr_evt = ptr_sync_reg[2] ^ ptr_sync_reg[1];
    assign start_evt = start_sync_reg[2] ^ start_sync_reg[1];
    assign stop_evt = stop_sync_reg[2] ^ stop_sync_reg[1];

    always_ff @(posedge clk_in) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else if (start_evt || stop_evt) begin
            busy_reg <= start_evt;
        end
    end
    assign bus_busy_out = busy_reg;

    // =========================================================
    // Register bank and pointer
    // =========================================================
    rate_cfg_t rate_reg [2];
    logic [7:0] select_reg [4];
    logic [3:0] ptr_reg;
    logic auto_reg, want_ptr_reg;

    function automatic logic [3:0] advance(input logic [3:0] p,
                                           input logic [3:0] wrap);
        advance = (p >= last_reg_addr) ? wrap : p + 4'h1;
    endfunction

    // Marks the first data byte after a write address as the pointer byte.
    always_ff @(posedge clk_in) begin
        if (sys_rst) begin
            want_ptr_reg <= 1'b0;
        end else if (start_evt) begin
            want_ptr_reg <= 1'b1;
        end else if (byte_evt) begin
            want_ptr_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst) begin
            ptr_reg <= 4'h0;
            auto_reg <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                rate_reg[i] <= '{prescale_reset, duty_reset};
            end
            for (int i = 0; i < 4; i++) begin
                select_reg[i] <= select_reset;
            end
        end else if (byte_evt && want_ptr_reg) begin
            ptr_reg <= byte_hold_reg[3:0];
            auto_reg <= byte_hold_reg[auto_advance_bit];
        end else if (byte_evt) begin
            if (ptr_reg >= out_select_0_3_addr &&
                ptr_reg <= last_reg_addr) begin
                select_reg[2'(ptr_reg - out_select_0_3_addr)] <=
                    byte_hold_reg;
            end else if (ptr_reg >= rate0_prescale_addr &&
                         ptr_reg < out_select_0_3_addr) begin
                if (ptr_reg[0]) begin
                    rate_reg[ptr_reg[2]].duty <= byte_hold_reg;
                end else begin
                    rate_reg[ptr_reg[2]].prescale <= byte_hold_reg;
                end
            end
            if (auto_reg) begin
                ptr_reg <= advance(ptr_reg, write_wrap_addr);
            end
        end else if (ptr_evt && auto_reg) begin
            ptr_reg <= advance(ptr_reg, read_wrap_addr);
        end
    end

    // Read data for the current pointer, held in a register.
    always_ff @(posedge clk_in) begin
        if (sys_rst) begin
            tx_byte_reg <= 8'h00;
        end else begin
            case (ptr_reg)
                pin_input_low_addr: tx_byte_reg <= pin_sync_reg[7:0];
                pin_input_high_addr: tx_byte_reg <= pin_sync_reg[15:8];
                rate0_prescale_addr: tx_byte_reg <= rate_reg[0].prescale;
                rate0_duty_addr: tx_byte_reg <= rate_reg[0].duty;
                rate1_prescale_addr: tx_byte_reg <= rate_reg[1].prescale;
                rate1_duty_addr: tx_byte_reg <= rate_reg[1].duty;
                default: tx_byte_reg <= (ptr_reg <= last_reg_addr) ?
                    select_reg[2'(ptr_reg - out_select_0_3_addr)] : 8'h00;
            endcase
        end
    end

    // =========================================================
    // Dimming generators and output stage
    // =========================================================
    logic [15:0] tick_cnt_reg;
    logic tick;
    logic [7:0] pre_cnt_reg [2];
    logic [7:0] phase_reg [2];
    logic [1:0] dim_on;

    assign tick = tick_cnt_reg == 16'(tick_cycles - 1);
    always_ff @(posedge clk_in) begin
        if (sys_rst || tick) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end

    // Phase steps 256 times per period; prescale stretches each step.
    always_ff @(posedge clk_in) begin
        for (int r = 0; r < 2; r++) begin
            if (sys_rst) begin
                pre_cnt_reg[r] <= 8'h00;
                phase_reg[r] <= 8'h00;
            end else if (tick) begin
                if (pre_cnt_reg[r] >= rate_reg[r].prescale) begin
                    pre_cnt_reg[r] <= 8'h00;
                    phase_reg[r] <= phase_reg[r] + 8'h01;
                end else begin
                    pre_cnt_reg[r] <= pre_cnt_reg[r] + 8'h01;
                end
            end
        end
    end
    assign dim_on[0] = phase_reg[0] < rate_reg[0].duty;
    assign dim_on[1] = phase_reg[1] < rate_reg[1].duty;

    always_ff @(posedge clk_in) begin
        for (int n = 0; n < outputs; n++) begin
            if (sys_rst) begin
                drive_oe_out[n] <= 1'b0;
            end else begin
                case (select_reg[n / 4][2 * (n % 4) +: 2])
                    sel_hiz: drive_oe_out[n] <= 1'b0;
                    sel_low: drive_oe_out[n] <= 1'b1;
                    sel_rate0: drive_oe_out[n] <= dim_on[0];
                    sel_rate1: drive_oe_out[n] <= dim_on[1];
                    default: drive_oe_out[n] <= 1'b0;
                endcase
            end
        end
    end
    assign drive_out = '0;

endmodule

// >>> led_port_sva.sv
/*
 * Pin-level checks of the LED driver serial register port.
 * Assumes a serial clock half period of at least two clk_in cycles.
 */
`timescale 1ns/100ps
module led_port_sva
    import led_port_pkg::*;
#(
    parameter int outputs = 16
) (
    // System side
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic rst_n_in,
    // Serial side
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [2:0] addr_sel_in,
    // LED side
    input wire logic [outputs-1:0] drive_in,
    input wire logic [outputs-1:0] drive_out,
    input wire logic [outputs-1:0] drive_oe_out,
    input wire logic bus_busy_out
);
    // =========================================================
    // Bus conditions
    // =========================================================
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence start_seen;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence

    sequence stop_seen;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence

    // Starts seen in the last five cycles, for the busy cause check.
    logic [4:0] start_hist;
    always_ff @(posedge clk_in) begin
        start_hist <= {start_hist[3:0],
            scl_in && $past(scl_in) && $fell(sda_in)};
    end

    // =========================================================
    // Assertions
    // =========================================================
    reset_idle_a: assert property (disable iff (1'b0)
        $past(reset_in) |-> !sda_oe_out && !bus_busy_out && drive_oe_out == '0)
        else $error("outputs active just after reset");
    sda_only_low_a: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    drive_only_low_a: assert property (drive_out == '0)
        else $error("LED pin driven high");
    data_stable_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_out))
        else $error("data line changed while clock high");
    start_busy_a: assert property (
        start_seen |-> ##[1:5] bus_busy_out)
        else $error("start not seen as busy");
    stop_free_a: assert property (
        stop_seen |-> ##[1:5] !bus_busy_out)
        else $error("stop not seen as free");
    busy_cause_a: assert property (
        $rose(bus_busy_out) |-> start_hist != '0)
        else $error("busy without start");
    ack_in_frame_a: assert property (sda_oe_out |-> bus_busy_out)
        else $error("data line pulled while bus free");
    pin_reset_a: assert property (
        !rst_n_in [*6] |-> drive_oe_out == '0)
        else $error("outputs still active in pin reset");
endmodule

bind led_port led_port_sva #(.outputs(outputs)) led_port_sva_inst (
    .clk_in(clk_in), .reset_in(reset_in), .rst_n_in(rst_n_in),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .addr_sel_in(addr_sel_in),
    .drive_in(drive_in), .drive_out(drive_out),
    .drive_oe_out(drive_oe_out), .bus_busy_out(bus_busy_out)
);

// >>> bus_master_model.sv
/*
 * Serial bus master model that reads and writes the LED port registers.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/100ps
module bus_master_model (
    // Bus pins
    output logic scl_out,
    output logic line_oe_out,
    input wire logic sda_in
);
    // =========================================================
    // Bus cycles
    // =========================================================
    localparam int q = 12;
    logic busy = 1'b0;

    initial begin
        scl_out = 1'b1;
        line_oe_out = 1'b0;
    end

    task automatic put_bit(input logic b, output logic seen);
        scl_out = 1'b0;
        #q;
        line_oe_out = ~b;
        #q;
        scl_out = 1'b1;
        #q;
        seen = sda_in;
        #q;
    endtask

    task automatic start_cond();
        if (busy) begin
            scl_out = 1'b0;
            #q;
            line_oe_out = 1'b0;
            #q;
            scl_out = 1'b1;
            #q;
        end
        line_oe_out = 1'b1;
        #(2 * q);
        busy = 1'b1;
    endtask

    task automatic stop_cond();
        scl_out = 1'b0;
        #q;
        line_oe_out = 1'b1;
        #q;
        scl_out = 1'b1;
        #q;
        line_oe_out = 1'b0;
        #(4 * q);
        busy = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(last, s);
    endtask

    task automatic write_frame(input logic [6:0] dev, input logic [7:0] ptr,
            input logic [7:0] data [$], output logic ok);
        logic a;
        start_cond();
        send_byte({dev, 1'b0}, ok);
        if (ok) begin
            send_byte(ptr & 8'h1f, a);
            ok = ok & a;
            foreach (data[i]) begin
                send_byte(data[i], a);
                ok = ok & a;
            end
        end
        stop_cond();
    endtask

    task automatic read_frame(input logic [6:0] dev, input logic [7:0] ptr,
            input int n, output logic [7:0] data [$]);
        logic a;
        logic [7:0] b;
        data = {};
        start_cond();
        send_byte({dev, 1'b0}, a);
        send_byte(ptr & 8'h1f, a);
        start_cond();
        send_byte({dev, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            get_byte(i == n - 1, b);
            data.push_back(b);
        end
        stop_cond();
    endtask
endmodule

// >>> tb.sv
/*
 * Self-checking bench of the LED port: a master model on the serial pins.
 * Assumes pulled-up LED pins carrying a fixed outside pattern.
 */
`timescale 1ns/100ps
`define check(what, exp, seen) \
    tests_run++; \
    if ((seen) !== (exp)) begin \
        $display("unexpected %s expected %h seen %h", what, exp, seen); \
        fail_count++; \
    end

module tb
    import led_port_pkg::*;
;
    // =========================================================
    // Bench wiring
    // =========================================================
    logic clk_in;
    logic reset_in;
    logic rst_n_in;
    logic [2:0] addr_sel_in;
    logic [15:0] pin_level;
    logic [7:0] got [$];
    logic ok;
    int fail_count = 0;
    int tests_run = 0;
    wire scl;
    wire m_oe;
    wire sda_oe;
    wire busy;
    wire [15:0] drive_oe;
    wire sda = ~(m_oe | sda_oe);
    wire [15:0] drive_in = pin_level & ~drive_oe;
    wire [6:0] dev = {fixed_addr_high, addr_sel_in};

    led_port led_port_inst (.clk_in(clk_in), .reset_in(reset_in),
        .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe_out(sda_oe), .addr_sel_in(addr_sel_in), .drive_in(drive_in),
        .drive_out(), .drive_oe_out(drive_oe), .bus_busy_out(busy));
    bus_master_model bus_master_model_inst (.scl_out(scl),
        .line_oe_out(m_oe), .sda_in(sda));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic check_bytes(input logic [7:0] exp [$]);
        foreach (exp[i]) begin
            `check("register byte", exp[i], got[i])
        end
    endtask

    task automatic test_defaults();
        bus_master_model_inst.read_frame(dev, 8'h12, 10, got);
        check_bytes({prescale_reset, duty_reset, prescale_reset, duty_reset,
            select_reset, select_reset, select_reset, select_reset,
            pin_level[7:0], pin_level[15:8]});
    endtask

    task automatic test_write_wrap();
        bus_master_model_inst.write_frame(dev, 8'h18,
            {8'h55, 8'he4, 8'h3c, 8'hc4, 8'h00, 8'h00}, ok);
        `check("write acks", 1'b1, ok)
        repeat (4) @(negedge clk_in);
        `check("drive enables", 16'h6f00, drive_oe)
        `check("bus free", 1'b0, busy)
        bus_master_model_inst.read_frame(dev, 8'h10, 10, got);
        check_bytes({pin_level[7:0], pin_level[15:8] & 8'h90, 8'h3c, 8'hc4,
            8'h00, 8'h00, select_reset, select_reset,
            8'h55, 8'he4});
    endtask

    task automatic test_read_only();
        bus_master_model_inst.write_frame(dev, 8'h10,
            {8'hff, 8'hff, 8'h77}, ok);
        `check("input write acks", 1'b1, ok)
        bus_master_model_inst.read_frame(dev, 8'h10, 3, got);
        check_bytes({pin_level[7:0], pin_level[15:8] & 8'h90,
            8'h77});
    endtask

    task automatic test_no_advance();
        bus_master_model_inst.write_frame(dev, 8'h05,
            {8'h11, 8'h22, 8'h33}, ok);
        `check("fixed write acks", 1'b1, ok)
        repeat (4) @(negedge clk_in);
        `check("dim enables", 16'hef00, drive_oe)
        bus_master_model_inst.read_frame(dev, 8'h14, 3, got);
        check_bytes({prescale_reset, 8'h33, select_reset});
    endtask

    task automatic test_address();
        bus_master_model_inst.write_frame({fixed_addr_high, 3'h2}, 8'h02,
            {8'h99}, ok);
        `check("foreign address ack", 1'b0, ok)
        @(negedge clk_in);
        addr_sel_in = 3'h2;
        repeat (4) @(negedge clk_in);
        bus_master_model_inst.read_frame(dev, 8'h02, 1, got);
        check_bytes({8'h77});
    endtask

    task automatic test_pin_reset();
        rst_n_in = 1'b0;
        repeat (8) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        `check("enables after pin reset", 16'h0000, drive_oe)
        bus_master_model_inst.read_frame(dev, 8'h12, 2, got);
        check_bytes({prescale_reset, duty_reset});
    endtask

    // =========================================================
    // Run control
    // =========================================================
    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        reset_in = 1'b1;
        rst_n_in = 1'b1;
        addr_sel_in = 3'h5;
        pin_level = 16'ha5c3;
        repeat (8) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (4) @(negedge clk_in);
        test_defaults();
        test_write_wrap();
        test_read_only();
        test_no_advance();
        @(negedge clk_in);
        test_address();
        @(negedge clk_in);
        test_pin_reset();
        complete_run();
    end

    initial begin
        repeat (100000) @(posedge clk_in);
        fail_count++;
        complete_run();
    end
endmodule
